// ==== rtl/peripheral_soft_reset_control.sv ====
// Purpose: software-driven reset requests for on-chip peripherals
// Assumes: capability masks come from logic on mclk_i, so they are not resynchronised
// Notes:   one wait state on every bus access; unmapped addresses answer with err
`timescale 1ns/100ps

// Functional notes
// - writes to bank a are ANDed bit by bit with capability mask a
// - writes to bank b are ANDed bit by bit with capability mask b
// - bank a bit 16 is read/write and drives the converter reset request
// - bank a bit 6 is read/write and drives the hibernation unit reset request
// - bank a bit 3 is read/write and drives the watchdog reset request
// - bank b bits 26..24 drive comparators c, b, a reset requests; read/write
// - bank b bits 19..16 drive general-purpose counters d..a reset requests
// - bank b bit 4 is read/write and drives the synchronous serial reset request
// - bank b bits 1 and 0 drive serial ports b and a reset requests
// - both banks clear to zero on system reset
// - unassigned bits read zero and ignore writes; software should preserve them
module peripheral_soft_reset_control
  import soft_reset_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = 12
) (
  input  wire logic                  mclk_i,
  input  wire logic                  resetn_i,
  input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_cyc_i,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  input  wire logic [31:0]           capability_mask_a_i,
  input  wire logic [31:0]           capability_mask_b_i,
  output logic                       adc_reset_o,
  output logic                       hibernation_reset_o,
  output logic                       watchdog_reset_o,
  output logic      [2:0]            comparator_reset_o,
  output logic      [3:0]            gp_counter_reset_o,
  output logic                       sync_serial_reset_o,
  output logic      [1:0]            serial_port_reset_o
);

  if (ADDR_WIDTH < OFFSET_WIDTH || ADDR_WIDTH > 32) begin : g_bad_addr_width
    $error("ADDR_WIDTH must lie between the register offset width and 32");
  end

  // bus request and response tracking
  logic                  request;
  logic                  resp_q;
  logic                  resp_d;
  logic                  hit_q;
  logic                  hit_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;
  logic                  commit;
  logic [31:0]           lane_mask;

  // address decode
  logic [ADDR_WIDTH-1:0] word_addr;
  logic                  sel_bank_a;
  logic                  sel_bank_b;
  logic                  sel_status;
  logic                  addr_hit;

  // register state
  logic [31:0]           bank_a_q;
  logic [31:0]           bank_b_q;
  logic [31:0]           bank_a_wmask;
  logic [31:0]           bank_b_wmask;
  logic [31:0]           bank_a_wdata;
  logic [31:0]           bank_b_wdata;
  logic                  write_bank_a;
  logic                  write_bank_b;
  logic                  write_status;

  // masked-write sticky flags
  logic [1:0]            masked_write_q;
  logic [1:0]            masked_write_d;
  logic [1:0]            masked_write_set;
  logic [1:0]            masked_write_clr;
  logic                  any_reset_active;
  logic [31:0]           status_word;
  logic [31:0]           read_mux;

  assign request   = wb_cyc_i & wb_stb_i;
  // word aligned: the two low address bits do not take part in the decode
  assign word_addr = {wb_adr_i[ADDR_WIDTH-1:2], 2'b00};

  assign sel_bank_a = (word_addr == ADDR_WIDTH'(PERIPHERAL_RESET_BANK_A_OFFSET));
  assign sel_bank_b = (word_addr == ADDR_WIDTH'(PERIPHERAL_RESET_BANK_B_OFFSET));
  assign sel_status = (word_addr == ADDR_WIDTH'(MASKED_WRITE_STATUS_OFFSET));
  assign addr_hit   = sel_bank_a | sel_bank_b | sel_status;

  // response comes one cycle after the request is seen, and drops the cycle after
  assign resp_d = request & ~resp_q;
  assign hit_d  = addr_hit;

  assign wb_ack_o = resp_q & hit_q;
  assign wb_err_o = resp_q & ~hit_q;
  assign wb_dat_o = rdata_q;

  // write takes effect on the edge at which the master samples ack
  assign commit = resp_q & hit_q & request & wb_we_i;

  // byte lane enables expanded to bit level
  genvar lane;
  for (lane = 0; lane < 4; lane++) begin : g_lane
    assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
  end

  assign write_bank_a = commit & sel_bank_a;
  assign write_bank_b = commit & sel_bank_b;
  assign write_status = commit & sel_status;

  // only implemented bits in selected lanes may change; reserved bits never do
  assign bank_a_wmask = lane_mask & BANK_A_IMPLEMENTED_MASK;
  assign bank_b_wmask = lane_mask & BANK_B_IMPLEMENTED_MASK;

  // a one written for an absent unit is dropped here, before it can take effect
  assign bank_a_wdata = wb_dat_i & capability_mask_a_i;
  assign bank_b_wdata = wb_dat_i & capability_mask_b_i;

  // per-bit register cells; reserved positions are constant zero
  genvar b;
  for (b = 0; b < 32; b++) begin : g_bit
    if (BANK_A_IMPLEMENTED_MASK[b]) begin : g_a_impl
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          bank_a_q[b] <= PERIPHERAL_RESET_BANK_A_RESET[b];
        end else if (write_bank_a && bank_a_wmask[b]) begin
          bank_a_q[b] <= bank_a_wdata[b];
        end
      end
    end else begin : g_a_rsvd
      assign bank_a_q[b] = 1'b0;
    end
    if (BANK_B_IMPLEMENTED_MASK[b]) begin : g_b_impl
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          bank_b_q[b] <= PERIPHERAL_RESET_BANK_B_RESET[b];
        end else if (write_bank_b && bank_b_wmask[b]) begin
          bank_b_q[b] <= bank_b_wdata[b];
        end
      end
    end else begin : g_b_rsvd
      assign bank_b_q[b] = 1'b0;
    end
  end

  // sticky report of a write that tried to set a bit for an absent unit;
  // lets software notice that a unit it meant to reset is not present
  assign masked_write_set[MASKED_WRITE_A_BIT] =
    write_bank_a & |(wb_dat_i & bank_a_wmask & ~capability_mask_a_i);
  assign masked_write_set[MASKED_WRITE_B_BIT] =
    write_bank_b & |(wb_dat_i & bank_b_wmask & ~capability_mask_b_i);
  // write one to clear, low byte lane only
  assign masked_write_clr =
    {2{write_status & wb_sel_i[0]}} & wb_dat_i[MASKED_WRITE_B_BIT:MASKED_WRITE_A_BIT];
  // a new event in the clearing cycle is kept: set wins over clear
  assign masked_write_d = (masked_write_q & ~masked_write_clr) | masked_write_set;

  assign any_reset_active = |bank_a_q | |bank_b_q;

  always_comb begin
    status_word                                      = 32'h0000_0000;
    status_word[MASKED_WRITE_B_BIT:MASKED_WRITE_A_BIT] = masked_write_q;
    status_word[ANY_RESET_ACTIVE_BIT]                = any_reset_active;
  end

  // reserved bits of both banks read as zero through the constant cells
  assign read_mux = sel_bank_a ? bank_a_q :
                    sel_bank_b ? bank_b_q :
                    sel_status ? status_word : 32'h0000_0000;

  // read data is captured with the request so it is stable while ack is high
  assign rdata_d = (request && !resp_q && !wb_we_i) ? read_mux : rdata_q;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      resp_q  <= 1'b0;
      hit_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      resp_q  <= resp_d;
      hit_q   <= hit_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      masked_write_q <= MASKED_WRITE_STATUS_RESET;
    end else begin
      masked_write_q <= masked_write_d;
    end
  end

  // reset requests follow the stored bits directly: held while a bit reads one
  assign adc_reset_o            = bank_a_q[ADC_RESET_BIT];
  assign hibernation_reset_o    = bank_a_q[HIBERNATION_RESET_BIT];
  assign watchdog_reset_o       = bank_a_q[WATCHDOG_RESET_BIT];
  assign comparator_reset_o[0]  = bank_b_q[COMPARATOR_A_RESET_BIT];
  assign comparator_reset_o[1]  = bank_b_q[COMPARATOR_B_RESET_BIT];
  assign comparator_reset_o[2]  = bank_b_q[COMPARATOR_C_RESET_BIT];
  assign gp_counter_reset_o[0]  = bank_b_q[GP_COUNTER_A_RESET_BIT];
  assign gp_counter_reset_o[1]  = bank_b_q[GP_COUNTER_B_RESET_BIT];
  assign gp_counter_reset_o[2]  = bank_b_q[GP_COUNTER_C_RESET_BIT];
  assign gp_counter_reset_o[3]  = bank_b_q[GP_COUNTER_D_RESET_BIT];
  assign sync_serial_reset_o    = bank_b_q[SYNC_SERIAL_RESET_BIT];
  assign serial_port_reset_o[0] = bank_b_q[SERIAL_PORT_A_RESET_BIT];
  assign serial_port_reset_o[1] = bank_b_q[SERIAL_PORT_B_RESET_BIT];

endmodule

// ==== rtl/soft_reset_pkg.sv ====
// Purpose: shared constants for the peripheral soft reset control block
// Assumes: 32-bit classic wishbone register bus, byte addressed
// Notes:   offsets are byte addresses; field constants are bit positions
package soft_reset_pkg;

  localparam int unsigned     DATA_WIDTH = 32;
  localparam int unsigned     OFFSET_WIDTH = 12;

  // register byte offsets
  localparam logic [11:0] PERIPHERAL_RESET_BANK_A_OFFSET = 12'h040;
  localparam logic [11:0] PERIPHERAL_RESET_BANK_B_OFFSET = 12'h044;
  localparam logic [11:0] MASKED_WRITE_STATUS_OFFSET     = 12'h050;

  // reset values
  localparam logic [31:0] PERIPHERAL_RESET_BANK_A_RESET  = 32'h0000_0000;
  localparam logic [31:0] PERIPHERAL_RESET_BANK_B_RESET  = 32'h0000_0000;
  localparam logic [1:0]  MASKED_WRITE_STATUS_RESET      = 2'h0;

  // bank a fields
  localparam int unsigned     ADC_RESET_BIT              = 16;
  localparam int unsigned     HIBERNATION_RESET_BIT      = 6;
  localparam int unsigned     WATCHDOG_RESET_BIT         = 3;

  // bank b fields
  localparam int unsigned     COMPARATOR_A_RESET_BIT     = 24;
  localparam int unsigned     COMPARATOR_B_RESET_BIT     = 25;
  localparam int unsigned     COMPARATOR_C_RESET_BIT     = 26;
  localparam int unsigned     GP_COUNTER_A_RESET_BIT     = 16;
  localparam int unsigned     GP_COUNTER_B_RESET_BIT     = 17;
  localparam int unsigned     GP_COUNTER_C_RESET_BIT     = 18;
  localparam int unsigned     GP_COUNTER_D_RESET_BIT     = 19;
  localparam int unsigned     SYNC_SERIAL_RESET_BIT      = 4;
  localparam int unsigned     SERIAL_PORT_A_RESET_BIT    = 0;
  localparam int unsigned     SERIAL_PORT_B_RESET_BIT    = 1;

  // implemented-bit masks; every other position is reserved
  localparam logic [31:0] BANK_A_IMPLEMENTED_MASK        = 32'h0001_0048;
  localparam logic [31:0] BANK_B_IMPLEMENTED_MASK        = 32'h070F_0013;

  // status register fields
  localparam int unsigned     MASKED_WRITE_A_BIT         = 0;
  localparam int unsigned     MASKED_WRITE_B_BIT         = 1;
  localparam int unsigned     ANY_RESET_ACTIVE_BIT       = 8;

endpackage

// ==== verification/soft_reset_sva.sv ====
// Purpose: bus timing and field checks for the soft reset block
// Assumes: only top ports visible; answer one cycle after a taken request
// Notes:   ports grouped per line to stay compact
`timescale 1ns/100ps
module soft_reset_sva
  import soft_reset_pkg::*;
#(parameter int unsigned ADDR_WIDTH = 12) (
  input wire logic                  mclk_i, resetn_i, wb_we_i, wb_stb_i, wb_cyc_i,
  input wire logic                  wb_ack_o, wb_err_o, adc_reset_o, hibernation_reset_o,
  input wire logic                  watchdog_reset_o, sync_serial_reset_o,
  input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0]            wb_sel_i, gp_counter_reset_o,
  input wire logic [31:0]           wb_dat_i, wb_dat_o, capability_mask_a_i, capability_mask_b_i,
  input wire logic [2:0]            comparator_reset_o,
  input wire logic [1:0]            serial_port_reset_o
);
  wire logic [ADDR_WIDTH-1:0] adr_w = {wb_adr_i[ADDR_WIDTH-1:2], 2'b00};
  wire logic hit_a = adr_w == ADDR_WIDTH'(PERIPHERAL_RESET_BANK_A_OFFSET);
  wire logic hit_b = adr_w == ADDR_WIDTH'(PERIPHERAL_RESET_BANK_B_OFFSET);
  wire logic hit_s = adr_w == ADDR_WIDTH'(MASKED_WRITE_STATUS_OFFSET);
  wire logic take = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
  wire logic wr_a = wb_ack_o & wb_we_i & hit_a;
  wire logic wr_b = wb_ack_o & wb_we_i & hit_b;
  wire logic [31:0] rd_a = {15'h0, adc_reset_o, 9'h0, hibernation_reset_o, 2'h0,
                            watchdog_reset_o, 3'h0};
  wire logic [31:0] rd_b = {5'h0, comparator_reset_o, 4'h0, gp_counter_reset_o, 11'h0,
                            sync_serial_reset_o, 2'h0, serial_port_reset_o};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  property p_ack; take && (hit_a || hit_b || hit_s) |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing or not one cycle");
  property p_err; take && !(hit_a || hit_b || hit_s) |=> wb_err_o && !wb_ack_o; endproperty
  a_err: assert property (p_err) else $error("err missing for unmapped access");
  property p_reset;
    $rose(resetn_i) |-> rd_a == 32'h0000_0000 && rd_b == 32'h0000_0000;
  endproperty
  a_reset: assert property (p_reset) else $error("reset outputs not clear");
  property p_adc;
    wr_a && wb_sel_i[2] |=> adc_reset_o == $past(wb_dat_i[16] & capability_mask_a_i[16]);
  endproperty
  a_adc: assert property (p_adc) else $error("bank a lane 2 write wrong");
  property p_lo_a; wr_a && wb_sel_i[0] |=> {hibernation_reset_o, watchdog_reset_o} ==
    $past({wb_dat_i[6] & capability_mask_a_i[6], wb_dat_i[3] & capability_mask_a_i[3]});
  endproperty
  a_lo_a: assert property (p_lo_a) else $error("bank a lane 0 write wrong");
  property p_comp; wr_b && wb_sel_i[3] |=>
    comparator_reset_o == $past(wb_dat_i[26:24] & capability_mask_b_i[26:24]); endproperty
  a_comp: assert property (p_comp) else $error("comparator bits wrong");
  property p_gp; wr_b && wb_sel_i[2] |=>
    gp_counter_reset_o == $past(wb_dat_i[19:16] & capability_mask_b_i[19:16]); endproperty
  a_gp: assert property (p_gp) else $error("counter bits wrong");
  property p_lo_b; wr_b && wb_sel_i[0] |=> {sync_serial_reset_o, serial_port_reset_o} ==
    $past({wb_dat_i[4], wb_dat_i[1:0]} & {capability_mask_b_i[4], capability_mask_b_i[1:0]});
  endproperty
  a_lo_b: assert property (p_lo_b) else $error("serial bits wrong");
  property p_read; wb_ack_o && !wb_we_i && (hit_a || hit_b) |-> wb_dat_o == (hit_a ? rd_a : rd_b);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  property p_hold; !$stable(rd_a) || !$stable(rd_b) |-> $past(wr_a || wr_b); endproperty
  a_hold: assert property (p_hold) else $error("reset output moved without write");
  c_wr_a: cover property (wr_a && wb_sel_i == 4'hf);
  c_wr_b: cover property (wr_b && wb_sel_i == 4'hf);
  c_err: cover property (wb_err_o);
endmodule

bind peripheral_soft_reset_control soft_reset_sva #(.ADDR_WIDTH(ADDR_WIDTH)) soft_reset_sva_i (
  .mclk_i, .resetn_i, .wb_we_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .wb_err_o, .adc_reset_o,
  .hibernation_reset_o, .watchdog_reset_o, .sync_serial_reset_o, .wb_adr_i, .wb_sel_i,
  .gp_counter_reset_o, .wb_dat_i, .wb_dat_o, .capability_mask_a_i, .capability_mask_b_i,
  .comparator_reset_o, .serial_port_reset_o);

// ==== verification/tb.sv ====
// Purpose: random and corner tests of the soft reset register block
// Assumes: one clock, synchronous active-low reset, classic wishbone master
// Notes:   a bench model of both banks gives the expected bank and output values; err and status checks use constants
`timescale 1ns/100ps
module tb;
  import soft_reset_pkg::*;
  logic        mclk_i = 0, resetn_i = 0, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0, e;
  logic [11:0] wb_adr_i = '0;
  logic [3:0]  wb_sel_i = '0, gp_counter_reset_o;
  logic [31:0] wb_dat_i = '0, capability_mask_a_i = '0, capability_mask_b_i = '0;
  logic [31:0] wb_dat_o, ma, mb, q;
  logic        wb_ack_o, wb_err_o, adc_reset_o, hibernation_reset_o, watchdog_reset_o;
  logic        sync_serial_reset_o;
  logic [2:0]  comparator_reset_o;
  logic [1:0]  serial_port_reset_o;
  logic [11:0] bad [3] = '{12'h048, 12'h03C, 12'hFFC};
  int          n_mismatch = 0, compares = 0;
  localparam logic [11:0] OFS_A = PERIPHERAL_RESET_BANK_A_OFFSET;
  localparam logic [11:0] OFS_B = PERIPHERAL_RESET_BANK_B_OFFSET;
  always #12.5 mclk_i = ~mclk_i;
  peripheral_soft_reset_control #(.ADDR_WIDTH(12)) peripheral_soft_reset_control_i (
    .mclk_i, .resetn_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i,
    .wb_cyc_i, .wb_ack_o, .wb_err_o, .capability_mask_a_i, .capability_mask_b_i, .adc_reset_o,
    .hibernation_reset_o, .watchdog_reset_o, .comparator_reset_o, .gp_counter_reset_o,
    .sync_serial_reset_o, .serial_port_reset_o);
  wire logic [31:0] out_a = {15'h0, adc_reset_o, 9'h0, hibernation_reset_o, 2'h0,
                             watchdog_reset_o, 3'h0};
  wire logic [31:0] out_b = {5'h0, comparator_reset_o, 4'h0, gp_counter_reset_o, 11'h0,
                             sync_serial_reset_o, 2'h0, serial_port_reset_o};
  // absent units are written with zero, so software can always release them
  function automatic logic [31:0] upd(logic [31:0] old, d, cap, impl, logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & impl;
    return (old & ~m) | (d & cap & m);
  endfunction
  task automatic report_and_stop();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic w,
                     input logic [3:0] s);
    int n;
    @(posedge mclk_i);
    {wb_adr_i, wb_dat_i, wb_we_i, wb_sel_i, wb_cyc_i, wb_stb_i} <= {a, d, w, s, 2'b11};
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    e = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(a, d, 1'b1, s);
    if (a == OFS_A) ma = upd(ma, d, capability_mask_a_i, BANK_A_IMPLEMENTED_MASK, s);
    if (a == OFS_B) mb = upd(mb, d, capability_mask_b_i, BANK_B_IMPLEMENTED_MASK, s);
  endtask
  task automatic check_all();
    bus(OFS_A, 32'h0000_0000, 1'b0, 4'hf);
    chk("bank_a", q, ma);
    bus(OFS_B, 32'h0000_0000, 1'b0, 4'hf);
    chk("bank_b", q, mb);
    chk("outs_a", out_a, ma);
    chk("outs_b", out_b, mb);
  endtask
  initial begin
    void'($urandom(90701));
    ma = '0;
    mb = '0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    check_all();
    capability_mask_a_i <= 32'hFFFF_FFFF;
    capability_mask_b_i <= 32'hFFFF_FFFF;
    wr(OFS_A, 32'hFFFF_FFFF, 4'hf);
    wr(OFS_B, 32'hFFFF_FFFF, 4'hf);
    check_all();
    foreach (bad[j]) begin
      bus(bad[j], 32'h0000_0000, j[0], 4'hf);
      chk("err", {31'h0, e}, 32'h0000_0001);
    end
    check_all();
    for (int i = 0; i < 40; i++) begin
      capability_mask_a_i <= $urandom();
      capability_mask_b_i <= $urandom();
      wr(($urandom() & 1) ? OFS_A : OFS_B, $urandom(), 4'($urandom()));
      check_all();
    end
    capability_mask_a_i <= 32'hFFFF_FFFF;
    wr(OFS_A, 32'hFFFF_FFFF, 4'hf);
    check_all();
    resetn_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    ma = '0;
    mb = '0;
    check_all();
    // a write that tries to set bits of absent units is dropped and flagged
    capability_mask_a_i <= 32'h0000_0000;
    wr(OFS_A, 32'hFFFF_FFFF, 4'hf);
    check_all();
    bus(MASKED_WRITE_STATUS_OFFSET, 32'h0000_0000, 1'b0, 4'hf);
    chk("status", q, 32'h0000_0001);
    bus(MASKED_WRITE_STATUS_OFFSET, 32'h0000_0003, 1'b1, 4'h1);
    bus(MASKED_WRITE_STATUS_OFFSET, 32'h0000_0000, 1'b0, 4'hf);
    chk("status_clr", q, 32'h0000_0000);
    report_and_stop();
  end
endmodule
